// File: src/ssd_uart.sv
`timescale 1ns/10ps

module ssd_fifo #(
    parameter int W = 12,
    parameter int D = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW:0] cnt;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
    } ssd_fifo_st_t;

    ssd_fifo_st_t st_reg;
    ssd_fifo_st_t st_next;
    logic wr;
    logic rd;

    assign in_ready = st_reg.cnt != (AW+1)'(D);
    assign out_valid = st_reg.cnt != '0;
    assign out_data = st_reg.mem[st_reg.rp];
    assign wr = in_valid && in_ready;
    assign rd = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (wr) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (rd) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
        case ({wr, rd})
            2'b10: st_next.cnt = st_reg.cnt + 1'b1;
            2'b01: st_next.cnt = st_reg.cnt - 1'b1;
            default: st_next.cnt = st_reg.cnt;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule // ssd_fifo

// Summary of operation
// - status read then data access clears flags
// - long read clears receive flags except the active flag, not transmit
// - flags set after status read survive
// - a status word read, but not a long read, snapshots all flags
// - empty flag sets when holding loads shifter
// - complete flag set only when transmitter idle
// - full flag and error flags set together
// - active flag: start bit sets, idle clears
// - idle flag per idle type, off in wakeup
// - idle flag rearms only after full sets
// - overrun keeps held word, discards new words
// - noise only inside valid frames
// - three samples per bit, majority, disagreement=noise
// - noise flag appears with full flag
// - zero stop bit gives framing error
// - parity error appears with full flag
// - data address: reads receive, writes transmit
// - shifter adds start, parity, stop bits
// - low eight bits data, ninth in 9-bit
// - short idle counts any one, long after stop
// - word length selects eight or nine bits
// - wakeup mode suppresses receiver flags
module ssd_uart #(
    parameter int RX_DEPTH = ssd_pkg::SSD_RX_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic baud_tick16,
    input wire logic rx_in,
    output logic tx_out,
    input wire ssd_pkg::ssd_cfg_t cfg,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic reg_long_rd,
    input wire logic reg_sel,
    input wire logic [15:0] reg_wdata,
    output logic [31:0] reg_rdata
);
    import ssd_pkg::*;

    localparam ssd_state_t ST_RST = '{flags: SSD_FLAGS_RST, snap: '0, idle_arm: 1'b1,
        rx_hold: '0, tx_hold: '0, rx_st: SSD_RX_IDLE, rx_tk: '0, rx_bit: '0, rx_smp: '0,
        rx_sh: '0, rx_noise: 1'b0, rx_prev: 1'b1, idle_cnt: '0, tx_st: SSD_TX_IDLE,
        tx_tk: '0, tx_left: '0, tx_sh: '1, tx_en_prev: 1'b0, pre_pend: 1'b0, rdata: '0};

    ssd_state_t st_reg;
    ssd_state_t st_next;
    ssd_flags_t fs;
    ssd_flags_t fc;
    ssd_rxword_t fifo_in;
    ssd_rxword_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic push;
    logic pop;
    logic ovr_set;
    logic rx_start;
    logic frame_done;
    logic idle_evt;
    logic tx_load;
    logic tx_done;
    logic maj;
    logic mixed;
    logic [3:0] nbits;
    logic [7:0] idle_thr;
    logic [7:0] f8;
    logic [8:0] f9;
    logic rx_par;
    logic [15:0] status_word;
    logic [15:0] data_word;
    logic st_rd;
    logic dat_rd;
    logic dat_wr;

    assign tx_out = st_reg.tx_sh[0];
    assign reg_rdata = st_reg.rdata;
    assign pop = fifo_out_valid && !st_reg.flags.rx_buffer_full_flag;
    assign maj = (st_reg.rx_smp[0] & st_reg.rx_smp[1]) | (st_reg.rx_smp[0] & st_reg.rx_smp[2])
        | (st_reg.rx_smp[1] & st_reg.rx_smp[2]);
    assign mixed = !(&st_reg.rx_smp) && (|st_reg.rx_smp);
    assign nbits = cfg.word9 ? SSD_BITS9 : SSD_BITS8;
    assign idle_thr = cfg.word9 ? SSD_IDLE9 : SSD_IDLE8;
    // parity takes the top bit of the data field
    assign f8 = cfg.parity_en ? {^st_reg.tx_hold[6:0] ^ cfg.parity_odd, st_reg.tx_hold[6:0]}
        : st_reg.tx_hold[7:0];
    assign f9 = cfg.parity_en ? {^st_reg.tx_hold[7:0] ^ cfg.parity_odd, st_reg.tx_hold[7:0]}
        : st_reg.tx_hold;
    assign rx_par = (cfg.word9 ? ^st_reg.rx_sh : ^st_reg.rx_sh[7:0]) != cfg.parity_odd;
    assign status_word = {7'h00, st_reg.flags};
    assign data_word = {7'h00, st_reg.rx_hold};
    assign st_rd = reg_rd && !reg_long_rd && reg_sel == SSD_SEL_STATUS;
    assign dat_rd = reg_rd && !reg_long_rd && reg_sel == SSD_SEL_DATA;
    assign dat_wr = reg_wr && !reg_rd && !reg_long_rd && reg_sel == SSD_SEL_DATA;

    ssd_fifo #(.W($bits(ssd_rxword_t)), .D(RX_DEPTH)) u_rx_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(!st_reg.flags.rx_buffer_full_flag),
        .out_data(fifo_out)
    );

    always_comb begin
        st_next = st_reg;
        fs = '0;
        fc = '0;
        rx_start = 1'b0;
        frame_done = 1'b0;
        idle_evt = 1'b0;
        push = 1'b0;
        ovr_set = 1'b0;
        tx_load = 1'b0;
        tx_done = 1'b0;
        fifo_in = '{data: st_reg.rx_sh, noise_flag: st_reg.rx_noise | mixed,
            framing_error_flag: !maj,
            parity_error_flag: cfg.parity_en && rx_par};

        // receiver
        if (baud_tick16) begin
            st_next.rx_prev = rx_in;
            case (st_reg.rx_st)
                SSD_RX_IDLE: begin
                    if (cfg.rx_en && st_reg.rx_prev && !rx_in) begin
                        st_next.rx_st = SSD_RX_START;
                        st_next.rx_tk = '0;
                        st_next.rx_bit = '0;
                        st_next.rx_sh = '0;
                        st_next.rx_noise = 1'b0;
                        rx_start = 1'b1;
                    end
                end
                SSD_RX_START, SSD_RX_DATA, SSD_RX_STOP: begin
                    st_next.rx_tk = st_reg.rx_tk + 4'h1;
                    if (st_reg.rx_tk == SSD_SMP_A || st_reg.rx_tk == SSD_SMP_B
                        || st_reg.rx_tk == SSD_SMP_C) begin
                        st_next.rx_smp = {st_reg.rx_smp[1:0], rx_in};
                    end
                    if (st_reg.rx_tk == SSD_BIT_END) begin
                        case (st_reg.rx_st)
                            SSD_RX_START: begin
                                // false start: back to idle, noise not counted
                                st_next.rx_st = maj ? SSD_RX_IDLE : SSD_RX_DATA;
                                st_next.rx_noise = mixed;
                            end
                            SSD_RX_DATA: begin
                                st_next.rx_sh[st_reg.rx_bit] = maj;
                                st_next.rx_noise = st_reg.rx_noise | mixed;
                                st_next.rx_bit = st_reg.rx_bit + 4'h1;
                                if (st_reg.rx_bit == nbits - 4'h1) begin
                                    st_next.rx_st = SSD_RX_STOP;
                                end
                            end
                            default: begin
                                st_next.rx_st = SSD_RX_IDLE;
                                frame_done = 1'b1;
                            end
                        endcase
                    end
                end
                default: st_next.rx_st = SSD_RX_IDLE;
            endcase
            // idle line counter
            if (!rx_in || !cfg.rx_en || (cfg.idle_long && st_reg.rx_st != SSD_RX_IDLE)) begin
                st_next.idle_cnt = '0;
            end else if (st_reg.idle_cnt < idle_thr) begin
                st_next.idle_cnt = st_reg.idle_cnt + 8'h01;
                idle_evt = st_reg.idle_cnt == idle_thr - 8'h01;
            end
        end
        if (!cfg.rx_en) begin
            st_next.rx_st = SSD_RX_IDLE;
        end

        if (frame_done && cfg.rx_en && !cfg.rx_wakeup) begin
            if (st_reg.flags.ovr || !fifo_in_ready) begin
                ovr_set = 1'b1;
            end else begin
                push = 1'b1;
            end
        end
        if (pop) begin
            st_next.rx_hold = fifo_out.data;
            st_next.idle_arm = 1'b1;
        end
        fs.rx_buffer_full_flag = pop;
        fs.noise_flag = pop && fifo_out.noise_flag;
        fs.framing_error_flag = pop && fifo_out.framing_error_flag;
        fs.parity_error_flag = pop && fifo_out.parity_error_flag;
        fs.ovr = ovr_set;
        fs.rx_active_flag = rx_start && !cfg.rx_wakeup;
        fs.idle = idle_evt && st_reg.idle_arm && !cfg.rx_wakeup;
        fc.rx_active_flag = idle_evt || !cfg.rx_en;

        // transmitter
        st_next.tx_en_prev = cfg.tx_en;
        if (cfg.tx_en && !st_reg.tx_en_prev) begin
            st_next.pre_pend = 1'b1;
        end
        case (st_reg.tx_st)
            SSD_TX_IDLE: begin
                if (cfg.tx_en) begin
                    if (!st_reg.flags.tx_buffer_empty_flag) begin
                        tx_load = 1'b1;
                        fs.tx_buffer_empty_flag = 1'b1;
                        st_next.tx_sh = cfg.word9 ? {1'b1, f9, 1'b0}
                            : {2'b11, f8, 1'b0};
                    end else if (cfg.send_break) begin
                        tx_load = 1'b1;
                        st_next.tx_sh = '0;
                    end else if (st_reg.pre_pend) begin
                        tx_load = 1'b1;
                        st_next.tx_sh = '1;
                        st_next.pre_pend = 1'b0;
                    end
                end
                if (tx_load) begin
                    st_next.tx_st = SSD_TX_SHIFT;
                    st_next.tx_tk = '0;
                    st_next.tx_left = nbits + SSD_FMT_BITS;
                    fc.tx_complete_flag = 1'b1;
                end
            end
            SSD_TX_SHIFT: begin
                if (baud_tick16) begin
                    st_next.tx_tk = st_reg.tx_tk + 4'h1;
                    if (st_reg.tx_tk == SSD_BIT_END) begin
                        st_next.tx_sh = {1'b1, st_reg.tx_sh[10:1]};
                        st_next.tx_left = st_reg.tx_left - 4'h1;
                        if (st_reg.tx_left == SSD_LAST_BIT) begin
                            st_next.tx_st = SSD_TX_IDLE;
                            st_next.tx_sh = '1;
                            tx_done = 1'b1;
                        end
                    end
                end
            end
            default: st_next.tx_st = SSD_TX_IDLE;
        endcase
        fs.tx_complete_flag = tx_done && !(cfg.tx_en && (!st_reg.flags.tx_buffer_empty_flag
            || cfg.send_break || st_next.pre_pend));

        // register access and acknowledge sequence
        if (reg_long_rd) begin
            fc = fc | (st_reg.flags & SSD_RX_MASK);
            st_next.rdata = {status_word, data_word};
        end else if (st_rd) begin
            st_next.snap = st_reg.flags;
            st_next.rdata = {16'h0000, status_word};
        end else if (dat_rd) begin
            fc = fc | (st_reg.snap & SSD_RX_MASK);
            st_next.snap = st_reg.snap & ~SSD_RX_MASK;
            st_next.rdata = {16'h0000, data_word};
        end else if (dat_wr) begin
            st_next.tx_hold = reg_wdata[8:0];
            fc = fc | (st_reg.snap & SSD_TX_MASK);
            st_next.snap = st_reg.snap & ~SSD_TX_MASK;
        end
        if (fc.idle && st_reg.flags.idle && !pop) begin
            st_next.idle_arm = 1'b0;
        end
        // a set in the same cycle beats the clear
        st_next.flags = (st_reg.flags & ~fc) | fs;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_ack_rx;
        dat_rd && st_reg.snap.rx_buffer_full_flag && st_reg.flags.rx_buffer_full_flag
            |=> !st_reg.flags.rx_buffer_full_flag;
    endproperty
    a_ack_rx: assert property (p_ack_rx) else $error("rx full not cleared");

    property p_long_tx;
        reg_long_rd && st_reg.flags.tx_buffer_empty_flag |=> st_reg.flags.tx_buffer_empty_flag;
    endproperty
    a_long_tx: assert property (p_long_tx) else $error("long read hit tx flag");

    property p_late;
        dat_rd && st_reg.flags.rx_buffer_full_flag && !st_reg.snap.rx_buffer_full_flag
            |=> st_reg.flags.rx_buffer_full_flag;
    endproperty
    a_late: assert property (p_late) else $error("late flag lost");

    property p_snap;
        st_rd |=> st_reg.snap == $past(st_reg.flags);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot wrong");

    property p_txw;
        dat_wr |=> st_reg.tx_hold == $past(reg_wdata[8:0]);
    endproperty
    a_txw: assert property (p_txw) else $error("tx hold not written");

    property p_busy;
        st_reg.tx_st == SSD_TX_SHIFT |-> !st_reg.flags.tx_complete_flag;
    endproperty
    a_busy: assert property (p_busy) else $error("complete flag set while busy");

    property p_pop;
        pop |=> st_reg.flags.rx_buffer_full_flag && st_reg.rx_hold == $past(fifo_out.data)
            && (st_reg.flags.framing_error_flag || !$past(fifo_out.framing_error_flag));
    endproperty
    a_pop: assert property (p_pop) else $error("rx load wrong");

    property p_raf;
        rx_start && !cfg.rx_wakeup ##1 !idle_evt |=> st_reg.flags.rx_active_flag;
    endproperty
    a_raf: assert property (p_raf) else $error("active flag missing");

    property p_ovr;
        ovr_set |=> st_reg.flags.ovr && $stable(st_reg.rx_hold);
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missing");

    c_pop: cover property (pop);
    c_ovr: cover property (ovr_set);
    c_idle: cover property (fs.idle);
    c_break: cover property (pop && fifo_out.framing_error_flag && fifo_out.data == '0);
endmodule // ssd_uart

// File: pkg/ssd_pkg.sv
package ssd_pkg;

    localparam int SSD_RX_DEPTH = 16;

    // 16x oversampling: three samples mid-bit, bit ends at the last tick
    localparam logic [3:0] SSD_SMP_A = 4'h7;
    localparam logic [3:0] SSD_SMP_B = 4'h8;
    localparam logic [3:0] SSD_SMP_C = 4'h9;
    localparam logic [3:0] SSD_BIT_END = 4'hF;
    localparam logic [3:0] SSD_BITS8 = 4'h8;
    localparam logic [3:0] SSD_BITS9 = 4'h9;
    localparam logic [3:0] SSD_FMT_BITS = 4'h2;
    localparam logic [3:0] SSD_LAST_BIT = 4'h1;
    // idle line = one frame of ones, counted in 16x ticks
    localparam logic [7:0] SSD_IDLE8 = 8'hA0;
    localparam logic [7:0] SSD_IDLE9 = 8'hB0;

    localparam logic SSD_SEL_STATUS = 1'b0;
    localparam logic SSD_SEL_DATA = 1'b1;

    // field order gives the status word layout, bit 8 down to bit 0
    typedef struct packed {
        logic tx_buffer_empty_flag;
        logic tx_complete_flag;
        logic rx_buffer_full_flag;
        logic rx_active_flag;
        logic idle;
        logic ovr;
        logic noise_flag;
        logic framing_error_flag;
        logic parity_error_flag;
    } ssd_flags_t;

    localparam ssd_flags_t SSD_FLAGS_RST = 9'h180;
    localparam ssd_flags_t SSD_RX_MASK = 9'h05F;
    localparam ssd_flags_t SSD_TX_MASK = 9'h180;

    typedef struct packed {
        logic word9;
        logic parity_en;
        logic parity_odd;
        logic idle_long;
        logic rx_wakeup;
        logic send_break;
        logic tx_en;
        logic rx_en;
    } ssd_cfg_t;

    typedef struct packed {
        logic [8:0] data;
        logic noise_flag;
        logic framing_error_flag;
        logic parity_error_flag;
    } ssd_rxword_t;

    typedef enum logic [3:0] {
        SSD_RX_IDLE = 4'b0001,
        SSD_RX_START = 4'b0010,
        SSD_RX_DATA = 4'b0100,
        SSD_RX_STOP = 4'b1000
    } ssd_rxst_t;

    typedef enum logic [1:0] {
        SSD_TX_IDLE = 2'b01,
        SSD_TX_SHIFT = 2'b10
    } ssd_txst_t;

    typedef struct packed {
        ssd_flags_t flags;
        ssd_flags_t snap;
        logic idle_arm;
        logic [8:0] rx_hold;
        logic [8:0] tx_hold;
        ssd_rxst_t rx_st;
        logic [3:0] rx_tk;
        logic [3:0] rx_bit;
        logic [2:0] rx_smp;
        logic [8:0] rx_sh;
        logic rx_noise;
        logic rx_prev;
        logic [7:0] idle_cnt;
        ssd_txst_t tx_st;
        logic [3:0] tx_tk;
        logic [3:0] tx_left;
        logic [10:0] tx_sh;
        logic tx_en_prev;
        logic pre_pend;
        logic [31:0] rdata;
    } ssd_state_t;

endpackage

// File: testbench/ssd_remote.sv
`timescale 1ns/10ps

module ssd_remote (
    input wire logic mclk,
    input wire logic baud_tick16,
    input wire logic tx_out,
    input wire logic word9,
    output logic rx_in
);
    logic [8:0] got_q[$];

    initial begin
        rx_in = 1'b1;
    end

    // bit 0 of frm goes first; glitch flips tick 8 of one bit, which the receiver takes as its first sample
    task automatic send(input logic [10:0] frm, input int n, input int glitch);
        for (int i = 0; i < n; i++) begin
            for (int t = 0; t < 16; t++) begin
                @(posedge mclk iff baud_tick16);
                rx_in <= frm[i] ^ (i == glitch && t == 8);
            end
        end
        @(posedge mclk iff baud_tick16);
        rx_in <= 1'b1;
    endtask

    // decodes frames on the line, keeps only those with a good stop bit
    always begin : rx_mon
        logic [8:0] w;
        int n;
        @(posedge mclk iff (baud_tick16 && !tx_out));
        n = word9 ? 9 : 8;
        w = '0;
        repeat (8) @(posedge mclk iff baud_tick16);
        for (int i = 0; i < n; i++) begin
            repeat (16) @(posedge mclk iff baud_tick16);
            w[i] = tx_out;
        end
        repeat (16) @(posedge mclk iff baud_tick16);
        if (tx_out === 1'b1) begin
            got_q.push_back(w);
        end
    end
endmodule // ssd_remote

// File: testbench/tb_top.sv
`timescale 1ns/10ps

module tb_top;
    import ssd_pkg::*;
    logic mclk, sys_rst, rx_in, tx_out;
    logic baud_tick16 = 1'b0;
    logic reg_rd, reg_wr, reg_long_rd, reg_sel;
    logic [15:0] reg_wdata;
    logic [31:0] reg_rdata, st, dt;
    logic [8:0] d;
    logic [1:0] tcnt = 2'h0;
    ssd_cfg_t cfg;
    int n_mismatch, num_checks;
    logic [8:0] wd[$];

    ssd_uart i_ssd_uart (.mclk(mclk), .sys_rst(sys_rst), .baud_tick16(baud_tick16),
        .rx_in(rx_in), .tx_out(tx_out), .cfg(cfg), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_long_rd(reg_long_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    ssd_remote i_ssd_remote (.mclk(mclk), .baud_tick16(baud_tick16), .tx_out(tx_out),
        .word9(cfg.word9), .rx_in(rx_in));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // 16x tick every fourth clock
    always @(posedge mclk) begin
        tcnt <= tcnt + 2'h1;
        baud_tick16 <= (tcnt == 2'h3);
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_ser(input string what, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd(input logic sel, input logic lng, output logic [31:0] v);
        @(posedge mclk);
        reg_rd <= ~lng;
        reg_long_rd <= lng;
        reg_sel <= sel;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_long_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic wr(input logic [8:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_sel <= SSD_SEL_DATA;
        reg_wdata <= {7'h00, v};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // polls status until one of the masked flags shows
    task automatic poll(input logic [8:0] m);
        int i;
        i = 0;
        do begin
            rd(SSD_SEL_STATUS, 1'b0, st);
            i++;
        end while ((st[8:0] & m) == 9'h000 && i < 3000);
    endtask

    function automatic logic [8:0] fld(input logic [8:0] v, input int k, input logic bad);
        int w;
        w = (k == 1) ? 9 : 8;
        fld = (k == 1) ? v : {1'b0, v[7:0]};
        if (k == 2 || k == 3) begin
            fld[w - 1] = 1'b0;
            fld[w - 1] = (^fld) ^ (k == 3) ^ bad;
        end
    endfunction

    function automatic logic [10:0] mkframe(input logic [8:0] v, input int k);
        int w;
        w = (k == 1) ? 9 : 8;
        mkframe = {1'b1, fld(v, k, k == 3), 1'b0};
        mkframe[w + 1] = (k != 4);
    endfunction

    task automatic rx_send(input logic [8:0] v, input int k);
        i_ssd_remote.send(mkframe(v, k), (k == 1) ? 11 : 10, (k == 5) ? 3 : -1);
    endtask

    task automatic tx_check(input logic [8:0] v, input int k);
        logic [8:0] m;
        m = (k == 1) ? 9'h1FF : 9'h0FF;
        for (int i = 0; i < 3000 && i_ssd_remote.got_q.size() == 0; i++) @(posedge mclk);
        chk_ser("tx word", fld(v, k, 1'b0) & m,
            (i_ssd_remote.got_q.size() != 0) ? i_ssd_remote.got_q.pop_front() & m : 9'bx);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #1500000;
        n_mismatch++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        sys_rst = 1'b1;
        {reg_rd, reg_wr, reg_long_rd, reg_sel} = 4'h0;
        reg_wdata = 16'h0000;
        cfg = '0;
        cfg.rx_en = 1'b1;
        n_mismatch = 0;
        num_checks = 0;
        void'($urandom(32'h7EEA));
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(SSD_SEL_STATUS, 1'b0, st);
        chk("status after reset", 32'h180, st);
        @(posedge mclk);
        cfg.tx_en <= 1'b1;
        repeat (10) @(posedge mclk);
        poll(9'h080);
        poll(9'h010);
        chk("status idle", 32'h190, st);
        rd(SSD_SEL_DATA, 1'b0, dt);
        rd(SSD_SEL_STATUS, 1'b0, st);
        chk("idle acked", 32'h180, st);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            d = 9'($urandom);
            @(posedge mclk);
            cfg.word9 <= (k == 1);
            cfg.parity_en <= (k == 2 || k == 3);
            cfg.parity_odd <= (k == 3);
            rd(SSD_SEL_STATUS, 1'b0, st);
            wr(d);
            tx_check(d, k);
            poll(9'h080);
            chk("status tx idle", 32'h180, st);
            rx_send(d, k);
            poll(9'h010);
            chk("status rx", 32'h1D0 | ((k == 3) ? 32'h1 : (k == 4) ? 32'h2 :
                (k == 5) ? 32'h4 : 32'h0), st);
            rd(SSD_SEL_DATA, 1'b0, dt);
            chk("rx data", {23'h0, fld(d, k, k == 3)}, dt & ((k == 1) ? 32'h1FF : 32'hFF));
            rd(SSD_SEL_STATUS, 1'b0, st);
            chk("status after ack", 32'h180, st);
            $display("test kind %0d done", k);
        end
        @(posedge mclk);
        cfg <= 8'h13;
        // lone low tick: a false start, then an idle line while the flag is disarmed
        i_ssd_remote.send(11'h001, 1, 0);
        repeat (1000) @(posedge mclk);
        rd(SSD_SEL_STATUS, 1'b0, st);
        chk("idle not rearmed", 32'h180, st);
        d = 9'($urandom);
        rx_send(d, 0);
        repeat (64) @(posedge mclk);
        rd(SSD_SEL_DATA, 1'b0, dt);
        rd(SSD_SEL_STATUS, 1'b0, st);
        chk("late flag kept", 32'h40, st & 32'h40);
        poll(9'h010);
        rd(SSD_SEL_STATUS, 1'b1, st);
        chk("long read", {16'h01D0, 7'h00, 1'b0, d[7:0]}, st & 32'hFFFF00FF);
        rd(SSD_SEL_STATUS, 1'b0, st);
        chk("status after long", 32'h180, st);
        $display("test ack order done");
        @(posedge mclk);
        cfg.rx_wakeup <= 1'b1;
        rx_send(9'($urandom), 0);
        repeat (1000) @(posedge mclk);
        rd(SSD_SEL_STATUS, 1'b0, st);
        chk("wakeup quiet", 32'h180, st);
        @(posedge mclk);
        cfg.rx_wakeup <= 1'b0;
        d = 9'($urandom);
        rd(SSD_SEL_STATUS, 1'b0, st);
        wr(d);
        tx_check(d, 0);
        // no status read since the last write: this word is held, never sent
        wr(9'($urandom));
        repeat (1000) @(posedge mclk);
        chk("unsent write", 32'h0, i_ssd_remote.got_q.size());
        $display("test wakeup and tx hold done");
        for (int i = 0; i < 18; i++) begin
            wd.push_back(9'($urandom) & 9'h0FF);
            rx_send(wd[i], 0);
        end
        poll(9'h010);
        chk("status overrun", 32'h1D8, st);
        for (int i = 0; i < 17; i++) begin
            if (i > 0) begin
                poll(9'h040);
            end
            rd(SSD_SEL_DATA, 1'b0, dt);
            chk("drained word", {23'h0, wd[i]}, dt & 32'hFF);
        end
        rd(SSD_SEL_STATUS, 1'b0, st);
        chk("drained status", 32'h0, st & 32'h48);
        $display("test overrun done");
        @(posedge mclk);
        cfg.send_break <= 1'b1;
        repeat (200) @(posedge mclk);
        rd(SSD_SEL_STATUS, 1'b0, st);
        chk("break busy", 32'h100, st & 32'h180);
        @(posedge mclk);
        cfg.send_break <= 1'b0;
        poll(9'h080);
        chk("break done", 32'h180, st & 32'h180);
        $display("test break done");
        tally_and_finish();
    end
endmodule // tb_top
